// File: inc/rdp_params.svh
// Summary of operation
// - A step-down rail decays only when its rail decay enable bit is one.
// - Decay applies to downward code moves only; upward moves slew normally unless output is still above the code mid-decay.
// - While decaying the rail stops switching both transistors; its code still steps down.
// - During decay the rail's rail_ok is masked until output drops below OV.
// - Upward command mid-decay waits for the code ramp to reach output, then tracks.
// - Regulator 1 decodes its 4-bit code by table, 1.35 V to 3.3 V, 1111 unused.
// - Regulators 2 and 3 decode 0.70 V in 50 mV steps, code 1111 is 1.50 V.
// - Software sets each regulator code through registers 0x9a, 0x9b and 0xae.
// - Always-on regulator 1 stays enabled through emergency shutdown while supply valid.
// - Each source's rail_ok state is readable in status registers.
// - Each source is selectable per status output by a tree source mask bit.
// - Status outputs delay assertion: 0-15 ms, 0-100 ms, 5-100 ms, 0-100 ms.
// - In I2C control mode a status output drives a software-set level.
// - Stepping advances one code every 3 us for 10 mV or 6 us for 25 mV.
// - rail_ok is masked throughout dynamic voltage stepping, except during decay once output drops below OV.
`ifndef RDP_PARAMS_SVH
`define RDP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RDP_CLK_MHZ        100
`define RDP_STEP10_US      3
`define RDP_STEP25_US      6
`define RDP_STEP10_CYC     (`RDP_STEP10_US * `RDP_CLK_MHZ)
`define RDP_STEP25_CYC     (`RDP_STEP25_US * `RDP_CLK_MHZ)
`define RDP_MS_US          1000
`define RDP_MS_CYC         (`RDP_MS_US * `RDP_CLK_MHZ)

// ----------------------------------------------------------------------------
// Delay limits per status output, in ms
// ----------------------------------------------------------------------------
`define RDP_DLY_MIN        {7'd0, 7'd5, 7'd0, 7'd0}
`define RDP_DLY_MAX        {7'd100, 7'd100, 7'd100, 7'd15}

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RDP_OFS_LDO_A      8'h9a
`define RDP_OFS_LDO_B      8'h9b
`define RDP_OFS_LDO_C      8'hae
`define RDP_OFS_TARGET0    8'h20
`define RDP_OFS_DECAY_EN   8'h30
`define RDP_OFS_STEP_SIZE  8'h31
`define RDP_OFS_MASK0      8'h40
`define RDP_OFS_DELAY0     8'h50
`define RDP_OFS_OUT_MODE   8'h58
`define RDP_OFS_STAT0      8'h60
`define RDP_OFS_STAT_OUT   8'h63

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RDP_LDO_CODE_LSB   0
`define RDP_OUT_LEVEL_LSB  4
`define RDP_RST_LDO        8'h00
`define RDP_RST_TARGET     7'h00
`define RDP_RST_MASK       24'h000000
`define RDP_RST_DELAY      7'h00
`define RDP_RST_BYTE       8'h00

`endif

// File: inc/rdp_pkg.sv
package rdp_pkg;

  typedef enum logic [2:0] {
    RDP_IDLE,
    RDP_SLEW_UP,
    RDP_SLEW_DOWN,
    RDP_DECAY,
    RDP_CATCHUP
  } rdp_rail_state_t;

  typedef logic [6:0] rdp_code_t;

endpackage

// File: inc/rdp_rail_if.sv
`timescale 1ns/1ns
interface rdp_rail_if;
  import rdp_pkg::*;
  rdp_code_t [5:0] target;
  logic      [5:0] decay_en;
  logic      [5:0] step25;
  logic      [5:0] above_code;
  logic      [5:0] above_ov;
  rdp_code_t [5:0] code;
  logic      [5:0] switch_off;
  logic      [5:0] ok_mask;

  modport ctrl (
    input  target,
    input  decay_en,
    input  step25,
    input  above_code,
    input  above_ov,
    output code,
    output switch_off,
    output ok_mask
  );

  modport top (
    output target,
    output decay_en,
    output step25,
    output above_code,
    output above_ov,
    input  code,
    input  switch_off,
    input  ok_mask
  );
endinterface

// File: src/rdp_rail_ctrl.sv
`timescale 1ns/1ns
`include "rdp_params.svh"
module rdp_rail_ctrl
  import rdp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  rdp_rail_if.ctrl rif
);

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_rail
      rdp_rail_state_t st_r, st_nxt;
      rdp_code_t       code_r, code_nxt;
      logic [9:0]      cnt_r, cnt_nxt;
      logic            off_r, off_nxt;
      logic            msk_r, msk_nxt;
      logic            tick;
      rdp_code_t       tgt;

      assign tgt  = rif.target[gi];
      // Step interval depends on the step size of the rail.
      assign tick = (cnt_r == (rif.step25[gi] ? 10'(`RDP_STEP25_CYC - 1)
                                              : 10'(`RDP_STEP10_CYC - 1)));

      always_comb
      begin
        st_nxt   = st_r;
        code_nxt = code_r;
        cnt_nxt  = (st_r == RDP_IDLE || tick) ? 10'h000 : cnt_r + 10'h001;
        case (st_r)
          RDP_IDLE:
          begin
            if (tgt > code_r)
              st_nxt = RDP_SLEW_UP;
            else if (tgt < code_r)
              st_nxt = rif.decay_en[gi] ? RDP_DECAY : RDP_SLEW_DOWN;
          end
          RDP_SLEW_UP:
          begin
            if (tgt <= code_r)
              st_nxt = RDP_IDLE;
            else if (tick)
              code_nxt = code_r + 7'h01;
          end
          RDP_SLEW_DOWN:
          begin
            if (tgt >= code_r)
              st_nxt = RDP_IDLE;
            else if (tick)
              code_nxt = code_r - 7'h01;
          end
          RDP_DECAY:
          begin
            if (tgt > code_r)
              st_nxt = rif.above_code[gi] ? RDP_CATCHUP : RDP_SLEW_UP;
            else if (tgt < code_r && tick)
              code_nxt = code_r - 7'h01;
            else if (tgt == code_r && !rif.above_ov[gi])
              st_nxt = RDP_IDLE;
          end
          RDP_CATCHUP:
          begin
            // The code climbs toward the stranded output before switching resumes.
            if (tgt < code_r)
              st_nxt = RDP_DECAY;
            else if (!rif.above_code[gi])
              st_nxt = RDP_SLEW_UP;
            else if (tick && tgt > code_r)
              code_nxt = code_r + 7'h01;
          end
          default:
          begin
            st_nxt = RDP_IDLE;
          end
        endcase
        off_nxt = (st_nxt == RDP_DECAY) || (st_nxt == RDP_CATCHUP);
        if (st_nxt == RDP_DECAY)
          msk_nxt = rif.above_ov[gi];
        else
          msk_nxt = (st_nxt != RDP_IDLE);
      end

      always_ff @(posedge sys_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          st_r   <= RDP_IDLE;
          code_r <= `RDP_RST_TARGET;
          cnt_r  <= 10'h000;
          off_r  <= 1'b0;
          msk_r  <= 1'b0;
        end
        else
        begin
          st_r   <= st_nxt;
          code_r <= code_nxt;
          cnt_r  <= cnt_nxt;
          off_r  <= off_nxt;
          msk_r  <= msk_nxt;
        end
      end

      assign rif.code[gi]       = code_r;
      assign rif.switch_off[gi] = off_r;
      assign rif.ok_mask[gi]    = msk_r;
    end
  endgenerate

endmodule

// File: src/rdp_top.sv
`timescale 1ns/1ns
`include "rdp_params.svh"
module rdp_top
  import rdp_pkg::*;
#(
  parameter int MS_CYCLES = `RDP_MS_CYC
)
(
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  input  wire logic [5:0]      rail_raw_ok,
  input  wire logic [5:0]      rail_above_code,
  input  wire logic [5:0]      rail_above_ov,
  input  wire logic [5:0]      aux_raw_ok,
  input  wire logic [5:0]      control_input,
  input  wire logic            ldo1_always_on,
  input  wire logic            ldo1_enable_req,
  input  wire logic            system_supply_valid,
  input  wire logic            emergency_shutdown,
  output rdp_code_t [5:0]      rail_voltage_code,
  output logic      [5:0]      rail_switch_off,
  output logic      [11:0]     ldo1_mv,
  output logic      [11:0]     ldo2_mv,
  output logic      [11:0]     ldo3_mv,
  output logic                 ldo1_enable,
  output logic      [3:0]      status_out
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [2:0][7:0]  ldo_r, ldo_nxt;
  rdp_code_t [5:0]  tgt_r, tgt_nxt;
  logic [5:0]       dec_r, dec_nxt;
  logic [5:0]       s25_r, s25_nxt;
  logic [3:0][23:0] sel_r, sel_nxt;
  logic [3:0][6:0]  dly_r, dly_nxt;
  logic [7:0]       mode_r, mode_nxt;
  logic [7:0]       rdata_r, rdata_nxt;
  logic [23:0]      stat;

  rdp_rail_if rif ();

  assign rif.target     = tgt_r;
  assign rif.decay_en   = dec_r;
  assign rif.step25     = s25_r;
  assign rif.above_code = rail_above_code;
  assign rif.above_ov   = rail_above_ov;

  rdp_rail_ctrl u_rail (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .rif     (rif.ctrl)
  );

  // Bucks report not-ok while their indication is masked by a transition.
  assign stat = {6'h00, control_input, aux_raw_ok, rail_raw_ok & ~rif.ok_mask};

  always_comb
  begin
    ldo_nxt   = ldo_r;
    tgt_nxt   = tgt_r;
    dec_nxt   = dec_r;
    s25_nxt   = s25_r;
    sel_nxt   = sel_r;
    dly_nxt   = dly_r;
    mode_nxt  = mode_r;
    rdata_nxt = rdata_r;
    if (reg_wr)
    begin
      case (reg_addr)
        `RDP_OFS_LDO_A:     ldo_nxt[0] = reg_wdata;
        `RDP_OFS_LDO_B:     ldo_nxt[1] = reg_wdata;
        `RDP_OFS_LDO_C:     ldo_nxt[2] = reg_wdata;
        `RDP_OFS_DECAY_EN:  dec_nxt    = reg_wdata[5:0];
        `RDP_OFS_STEP_SIZE: s25_nxt    = reg_wdata[5:0];
        `RDP_OFS_OUT_MODE:  mode_nxt   = reg_wdata;
        default:
        begin
          for (int i = 0; i < 6; i++)
            if (reg_addr == `RDP_OFS_TARGET0 + 8'(i))
              tgt_nxt[i] = reg_wdata[6:0];
          for (int n = 0; n < 4; n++)
          begin
            for (int k = 0; k < 3; k++)
              if (reg_addr == `RDP_OFS_MASK0 + 8'(4 * n + k))
                sel_nxt[n][8 * k +: 8] = reg_wdata;
            if (reg_addr == `RDP_OFS_DELAY0 + 8'(n))
              dly_nxt[n] = reg_wdata[6:0];
          end
        end
      endcase
    end
    if (reg_rd)
    begin
      rdata_nxt = 8'h00;
      case (reg_addr)
        `RDP_OFS_LDO_A:     rdata_nxt = ldo_r[0];
        `RDP_OFS_LDO_B:     rdata_nxt = ldo_r[1];
        `RDP_OFS_LDO_C:     rdata_nxt = ldo_r[2];
        `RDP_OFS_DECAY_EN:  rdata_nxt = {2'b00, dec_r};
        `RDP_OFS_STEP_SIZE: rdata_nxt = {2'b00, s25_r};
        `RDP_OFS_OUT_MODE:  rdata_nxt = mode_r;
        `RDP_OFS_STAT_OUT:  rdata_nxt = {4'h0, status_out};
        default:
        begin
          for (int i = 0; i < 6; i++)
            if (reg_addr == `RDP_OFS_TARGET0 + 8'(i))
              rdata_nxt = {1'b0, tgt_r[i]};
          for (int k = 0; k < 3; k++)
            if (reg_addr == `RDP_OFS_STAT0 + 8'(k))
              rdata_nxt = stat[8 * k +: 8];
          for (int n = 0; n < 4; n++)
          begin
            for (int k = 0; k < 3; k++)
              if (reg_addr == `RDP_OFS_MASK0 + 8'(4 * n + k))
                rdata_nxt = sel_r[n][8 * k +: 8];
            if (reg_addr == `RDP_OFS_DELAY0 + 8'(n))
              rdata_nxt = {1'b0, dly_r[n]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ldo_r   <= {3{`RDP_RST_LDO}};
      tgt_r   <= {6{`RDP_RST_TARGET}};
      dec_r   <= 6'h00;
      s25_r   <= 6'h00;
      sel_r   <= {4{`RDP_RST_MASK}};
      dly_r   <= {4{`RDP_RST_DELAY}};
      mode_r  <= `RDP_RST_BYTE;
      rdata_r <= `RDP_RST_BYTE;
    end
    else
    begin
      ldo_r   <= ldo_nxt;
      tgt_r   <= tgt_nxt;
      dec_r   <= dec_nxt;
      s25_r   <= s25_nxt;
      sel_r   <= sel_nxt;
      dly_r   <= dly_nxt;
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Regulator code decode and always-on enable
  // --------------------------------------------------------------------------
  function automatic logic [11:0] ldo1_table(input logic [3:0] c);
    logic [11:0] mv;
    case (c)
      4'h0:    mv = 12'd1350;
      4'h1:    mv = 12'd1500;
      4'h2:    mv = 12'd1600;
      4'h3:    mv = 12'd1700;
      4'h4:    mv = 12'd1800;
      4'h5:    mv = 12'd1900;
      4'h6:    mv = 12'd2000;
      4'h7:    mv = 12'd2100;
      4'h8:    mv = 12'd2300;
      4'h9:    mv = 12'd2400;
      4'ha:    mv = 12'd2500;
      4'hb:    mv = 12'd2600;
      4'hc:    mv = 12'd2850;
      4'hd:    mv = 12'd3000;
      4'he:    mv = 12'd3300;
      default: mv = 12'd0;
    endcase
    return mv;
  endfunction

  function automatic logic [11:0] ldo23_table(input logic [3:0] c);
    logic [11:0] mv;
    mv = (c == 4'hf) ? 12'd1500 : 12'd700 + 12'(c) * 12'd50;
    return mv;
  endfunction

  logic [11:0] l1_nxt, l2_nxt, l3_nxt;
  logic        en_nxt;

  always_comb
  begin
    l1_nxt = ldo1_table(ldo_r[0][`RDP_LDO_CODE_LSB +: 4]);
    l2_nxt = ldo23_table(ldo_r[1][`RDP_LDO_CODE_LSB +: 4]);
    l3_nxt = ldo23_table(ldo_r[2][`RDP_LDO_CODE_LSB +: 4]);
    // An always-on regulator ignores shutdown but never the supply.
    en_nxt = system_supply_valid &
             (ldo1_always_on | (ldo1_enable_req & ~emergency_shutdown));
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ldo1_mv     <= 12'd0;
      ldo2_mv     <= 12'd0;
      ldo3_mv     <= 12'd0;
      ldo1_enable <= 1'b0;
    end
    else
    begin
      ldo1_mv     <= l1_nxt;
      ldo2_mv     <= l2_nxt;
      ldo3_mv     <= l3_nxt;
      ldo1_enable <= en_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Power-good tree and assertion delay
  // --------------------------------------------------------------------------
  localparam logic [27:0] DLY_MIN = `RDP_DLY_MIN;
  localparam logic [27:0] DLY_MAX = `RDP_DLY_MAX;

  logic [16:0]     ms_r, ms_nxt;
  logic            ms_tick;
  logic [3:0][6:0] dc_r, dc_nxt;
  logic [3:0]      tg_r, tg_nxt;
  logic [3:0]      out_nxt;

  assign ms_tick = (ms_r == 17'(MS_CYCLES - 1));

  always_comb
  begin
    logic       good;
    logic [6:0] lim;
    good   = 1'b0;
    lim    = 7'h00;
    ms_nxt = ms_tick ? 17'h00000 : ms_r + 17'h00001;
    for (int n = 0; n < 4; n++)
    begin
      good = &(stat[17:0] | ~sel_r[n][17:0]);
      lim  = dly_r[n];
      if (lim < DLY_MIN[7 * n +: 7])
        lim = DLY_MIN[7 * n +: 7];
      if (lim > DLY_MAX[7 * n +: 7])
        lim = DLY_MAX[7 * n +: 7];
      dc_nxt[n] = dc_r[n];
      tg_nxt[n] = tg_r[n];
      if (!good)
      begin
        dc_nxt[n] = 7'h00;
        tg_nxt[n] = 1'b0;
      end
      else if (!tg_r[n])
      begin
        if (dc_r[n] >= lim)
          tg_nxt[n] = 1'b1;
        else if (ms_tick)
          dc_nxt[n] = dc_r[n] + 7'h01;
      end
      out_nxt[n] = mode_r[n] ? mode_r[`RDP_OUT_LEVEL_LSB + n] : tg_nxt[n];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ms_r       <= 17'h00000;
      dc_r       <= '0;
      tg_r       <= 4'h0;
      status_out <= 4'h0;
    end
    else
    begin
      ms_r       <= ms_nxt;
      dc_r       <= dc_nxt;
      tg_r       <= tg_nxt;
      status_out <= out_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign rail_voltage_code = rif.code;
  assign rail_switch_off   = rif.switch_off;

endmodule

// File: tb/rdp_top_properties.sv
`timescale 1ns/1ns
module rdp_top_properties
  import rdp_pkg::*;
#(
  parameter int MS_CYCLES = 10
)
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        ldo1_always_on,
  input wire logic        system_supply_valid,
  input wire logic        emergency_shutdown,
  input rdp_code_t [5:0]  rail_voltage_code,
  input wire logic [11:0] ldo1_mv,
  input wire logic [11:0] ldo2_mv,
  input wire logic [11:0] ldo3_mv,
  input wire logic        ldo1_enable
);
  // ----
  // Decode tables in millivolts
  // ----
  localparam logic [11:0] MV1 [16] = '{12'h546, 12'h5dc, 12'h640, 12'h6a4, 12'h708, 12'h76c,
    12'h7d0, 12'h834, 12'h8fc, 12'h960, 12'h9c4, 12'ha28, 12'hb22, 12'hbb8, 12'hce4, 12'h000};
  localparam logic [11:0] MV2 [16] = '{12'h2bc, 12'h2ee, 12'h320, 12'h352, 12'h384, 12'h3b6,
    12'h3e8, 12'h41a, 12'h44c, 12'h47e, 12'h4b0, 12'h4e2, 12'h514, 12'h546, 12'h578, 12'h5dc};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_ldo1_decode: assert property (
    reg_wr && reg_addr == 8'h9a |-> ##2 ldo1_mv == MV1[$past(reg_wdata[3:0], 2)])
    else $error("regulator 1 millivolts wrong after code write");
  a_ldo2_decode: assert property (
    reg_wr && reg_addr == 8'h9b |-> ##2 ldo2_mv == MV2[$past(reg_wdata[3:0], 2)])
    else $error("regulator 2 millivolts wrong after code write");
  a_ldo3_decode: assert property (
    reg_wr && reg_addr == 8'hae |-> ##2 ldo3_mv == MV2[$past(reg_wdata[3:0], 2)])
    else $error("regulator 3 millivolts wrong after code write");
  a_always_on_kept: assert property (
    system_supply_valid && ldo1_always_on |=> ldo1_enable)
    else $error("always-on regulator dropped while supply valid");
  a_supply_loss_off: assert property (
    !system_supply_valid |=> !ldo1_enable)
    else $error("regulator 1 enabled without valid supply");
  a_shutdown_turns_off: assert property (
    system_supply_valid && !ldo1_always_on && emergency_shutdown |=> !ldo1_enable)
    else $error("regulator 1 left on through shutdown");
  a_unmapped_reads_zero: assert property (
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_code_single_step: assert property (
    $changed(rail_voltage_code[0]) |->
      rail_voltage_code[0] == $past(rail_voltage_code[0]) + 7'h01 ||
      rail_voltage_code[0] == $past(rail_voltage_code[0]) - 7'h01)
    else $error("rail code moved by more than one step");
  a_code_step_spacing: assert property (
    $changed(rail_voltage_code[0]) |=> $stable(rail_voltage_code[0])[*8])
    else $error("rail code stepped too soon");
endmodule

// File: tb/rdp_rail_model.sv
`timescale 1ns/1ns
module rdp_rail_model
  import rdp_pkg::*;
#(
  parameter int DECAY_CYC = 1000
)
(
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input rdp_code_t [5:0] rail_voltage_code,
  input rdp_code_t [5:0] rail_target,
  input wire logic [5:0] rail_switch_off,
  output logic     [5:0] rail_above_code,
  output logic     [5:0] rail_above_ov,
  output logic     [5:0] rail_raw_ok
);
  // ----
  // Output level of each rail, in code units
  // ----
  rdp_code_t [5:0] vout_r;
  int              tmr_r [6];

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vout_r <= '0;
      tmr_r <= '{default: 0};
    end
    else
    begin
      for (int i = 0; i < 6; i++)
      begin
        // Decay is slower than stepping on purpose, so the output lags the code.
        if (!rail_switch_off[i])
        begin
          vout_r[i] <= rail_voltage_code[i];
          tmr_r[i] <= 0;
        end
        else if (tmr_r[i] == DECAY_CYC - 1)
        begin
          if (vout_r[i] != 7'h00)
            vout_r[i] <= vout_r[i] - 7'h01;
          tmr_r[i] <= 0;
        end
        else
          tmr_r[i] <= tmr_r[i] + 1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      rail_above_code[i] = vout_r[i] > rail_voltage_code[i];
      // The over-voltage comparator follows the newly set target, not the stepping code.
      rail_above_ov[i] = vout_r[i] > rail_target[i] + 7'h01;
      rail_raw_ok[i] = vout_r[i] == rail_voltage_code[i];
    end
  end
endmodule

// File: tb/rdp_top_tb.sv
`timescale 1ns/1ns
module rdp_top_tb;
  import rdp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [5:0] rail_raw_ok, rail_above_code, rail_above_ov, rail_switch_off;
  logic [5:0] aux_raw_ok = 6'h01;
  logic [5:0] control_input = 6'h00;
  logic ldo1_always_on = 1'b0;
  logic ldo1_enable_req = 1'b1;
  logic system_supply_valid = 1'b1;
  logic emergency_shutdown = 1'b0;
  rdp_code_t [5:0] rail_voltage_code;
  rdp_code_t [5:0] rail_target = '0;
  logic [11:0] ldo1_mv, ldo2_mv, ldo3_mv;
  logic ldo1_enable;
  logic [3:0] status_out;
  int fails = 0;
  int tests_run = 0;
  localparam logic [11:0] L1 [16] = '{12'h546, 12'h5dc, 12'h640, 12'h6a4, 12'h708, 12'h76c,
    12'h7d0, 12'h834, 12'h8fc, 12'h960, 12'h9c4, 12'ha28, 12'hb22, 12'hbb8, 12'hce4, 12'h000};

  always #5 sys_clk = ~sys_clk;

  rdp_top #(.MS_CYCLES(10)) dut_u (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .rail_raw_ok, .rail_above_code, .rail_above_ov, .aux_raw_ok,
    .control_input, .ldo1_always_on, .ldo1_enable_req, .system_supply_valid,
    .emergency_shutdown, .rail_voltage_code, .rail_switch_off, .ldo1_mv, .ldo2_mv,
    .ldo3_mv, .ldo1_enable, .status_out);
  rdp_rail_model #(.DECAY_CYC(1000)) rail_u (.sys_clk, .sys_rst, .rail_voltage_code,
    .rail_target, .rail_switch_off, .rail_above_code, .rail_above_ov, .rail_raw_ok);

  // ----
  // Bus cycles and comparisons
  // ----
  task automatic final_report();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // The rail comparators see a target at the edge that takes the write.
    if (a[7:3] == 5'h04 && a[2:0] < 3'h6)
      rail_target[a[2:0]] <= d[6:0];
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    tick();
    chk({4'h0, reg_rdata}, {4'h0, e});
  endtask
  // A hung ramp would stall the run, so every wait gives up after a fixed bound.
  task automatic wcode(rdp_code_t v, output int n, output logic so);
    n = 0;
    so = 1'b0;
    do
    begin
      tick();
      n++;
      so |= rail_switch_off[0];
    end
    while (rail_voltage_code[0] !== v && n < 3000);
    chk(12'(n < 3000), 12'h001);
    if (n >= 3000)
      final_report();
  endtask
  task automatic sw(logic e);
    chk({11'h0, rail_switch_off[0]}, {11'h0, e});
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd(8'h9a, 8'h00);
    rd(8'hae, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_ldo();
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      wr(8'h9a, {4'ha, c});
      wr(8'h9b, {4'h0, c});
      wr(8'hae, {4'h5, ~c});
      tick(2);
      chk(ldo1_mv, L1[c]);
      chk(ldo2_mv, c == 4'hf ? 12'h5dc : 12'h2bc + 12'h032 * c);
      chk(ldo3_mv, c == 4'h0 ? 12'h5dc : 12'h2bc + 12'h032 * {8'h00, ~c});
      rd(8'h9a, {4'ha, c});
    end
    $display("test ldo done");
  endtask
  task automatic t_tree();
    int n1;
    int n3;
    wr(8'h49, 8'h10);
    wr(8'h52, 8'h00);
    wr(8'h40, 8'h40);
    wr(8'h41, 8'h10);
    wr(8'h50, 8'h03);
    tick(3);
    chk({8'h0, status_out & 4'h5}, 12'h000);
    n1 = 0;
    n3 = 0;
    @(posedge sys_clk);
    control_input <= 6'h01;
    for (int i = 1; i < 80; i++)
    begin
      tick();
      if (status_out[0] === 1'b1 && n1 == 0)
        n1 = i;
      if (status_out[2] === 1'b1 && n3 == 0)
        n3 = i;
    end
    chk(12'(n1 inside {[19:34]}), 12'h001);
    chk(12'(n3 inside {[39:54]}), 12'h001);
    @(posedge sys_clk);
    control_input <= 6'h00;
    tick(2);
    chk({8'h0, status_out & 4'h5}, 12'h000);
    chk({11'h0, status_out[1]}, 12'h001);
    chk({11'h0, status_out[3]}, 12'h001);
    wr(8'h58, 8'h11);
    tick(2);
    chk({11'h0, status_out[0]}, 12'h001);
    wr(8'h58, 8'h01);
    tick(2);
    chk({11'h0, status_out[0]}, 12'h000);
    $display("test tree done");
  endtask
  task automatic t_rails();
    int n;
    logic so;
    wr(8'h20, 8'h03);
    wcode(7'h01, n, so);
    wcode(7'h02, n, so);
    chk(12'(n inside {[299:301]}), 12'h001);
    rd(8'h60, 8'h7e);
    wcode(7'h03, n, so);
    tick(3);
    rd(8'h60, 8'h7f);
    wr(8'h31, 8'h01);
    wr(8'h20, 8'h01);
    wcode(7'h02, n, so);
    wcode(7'h01, n, so);
    chk(12'(n inside {[599:601]}), 12'h001);
    chk({11'h0, so}, 12'h000);
    $display("test rails done");
  endtask
  task automatic t_decay();
    int n;
    logic so;
    wr(8'h31, 8'h00);
    wr(8'h30, 8'h01);
    wr(8'h20, 8'h03);
    wcode(7'h03, n, so);
    chk({11'h0, so}, 12'h000);
    tick(3);
    wr(8'h20, 8'h01);
    tick(4);
    sw(1'b1);
    rd(8'h60, 8'h7e);
    n = 0;
    while (rail_switch_off[0] === 1'b1 && n < 3000)
    begin
      tick();
      n++;
    end
    chk(12'(n inside {[900:2999]}), 12'h001);
    if (n >= 3000)
      final_report();
    chk({5'h0, rail_voltage_code[0]}, 12'h001);
    tick(3);
    rd(8'h60, 8'h7f);
    $display("test decay done");
  endtask
  task automatic t_catchup();
    int n;
    logic so;
    wr(8'h20, 8'h03);
    wcode(7'h03, n, so);
    tick(3);
    wr(8'h20, 8'h00);
    wcode(7'h00, n, so);
    wr(8'h20, 8'h03);
    tick(10);
    sw(1'b1);
    wcode(7'h01, n, so);
    sw(1'b1);
    wcode(7'h03, n, so);
    sw(1'b0);
    $display("test catchup done");
  endtask
  task automatic t_enable();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge sys_clk);
      {system_supply_valid, ldo1_always_on, ldo1_enable_req, emergency_shutdown} <= i[3:0];
      tick(2);
      chk({11'h0, ldo1_enable}, {11'h0, i[3] & (i[2] | (i[1] & ~i[0]))});
    end
    $display("test enable done");
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_ldo();
    t_tree();
    t_rails();
    t_decay();
    t_catchup();
    t_enable();
    final_report();
  end
endmodule

bind rdp_top rdp_top_properties #(.MS_CYCLES(MS_CYCLES)) chk_u (.sys_clk, .sys_rst, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .ldo1_always_on, .system_supply_valid,
  .emergency_shutdown, .rail_voltage_code, .ldo1_mv, .ldo2_mv, .ldo3_mv, .ldo1_enable);
